//--- rtl/pmfsb_fault_status_bank.sv
/*
 * Status and diagnostic register bank of a digital power controller.
 * Assumes a serial protocol engine on ref_clk_i presents decoded command
 * reads and writes, and fault sources give one-cycle event pulses.
 */
`timescale 1ns/1ns
`include "pmfsb_consts.svh"
// Function
// - Comm/logic byte bit layout, bit 2 zero
// - Writing one clears only that bit
// - Unmasked set fault bits raise alert
// - Vendor byte bit layout
// - Any vendor bit sets summary bit
// - Log-present bit cleared only by log-clear
// - Pin word bits 15 to 10
// - Pin word bits 9 to 4
// - Pin word bits 3 to 0
// - Pin word read-only, one means true
// - Health byte layout, read-only
// - ECC word bit 5, rest zero
// - ECC bit refreshed on four events
// - Vendor alert mask resets to 0x11
// - Summary flag at status word bit 12
module pmfsb_fault_status_bank (
    input wire logic ref_clk_i,          // Core clock, 100 MHz
    input wire logic nrst_i,             // Async reset, active low
    input wire logic [7:0] cmd_code_i,   // Decoded command code
    input wire logic cmd_rd_i,           // Read strobe, one cycle
    input wire logic cmd_wr_i,           // Write strobe, one cycle
    input wire logic [15:0] cmd_wdata_i, // Write data
    output logic [15:0] cmd_rdata_o,     // Read data, registered
    output logic cmd_err_o,              // Unsupported access pulse
    input wire logic clear_faults_i,     // Clear-all-faults pulse
    input wire logic fault_log_clear_i,  // Fault-log-clear pulse
    input wire logic [7:0] cml_evt_i,    // Comm/logic fault events
    input wire logic [7:0] vnd_evt_i,    // Vendor fault events
    input wire logic core_ov_i,          // Core supply overvoltage
    input wire logic core_uv_i,          // Core supply undervoltage
    input wire logic adc_invalid_i,      // ADC values not valid
    input wire logic sync_ext_i,         // Sync pin clocked externally
    input wire logic [1:0] pgood_i,      // Channel power good
    input wire logic [1:0] run_drv_low_i,   // Device pulls run pins low
    input wire logic [1:0] fault_drv_low_i, // Device pulls fault pins low
    input wire logic channel0_run_pin_i,   // Run pin level, channel 0
    input wire logic channel1_run_pin_i,   // Run pin level, channel 1
    input wire logic channel0_fault_pin_i, // Fault pin level, channel 0
    input wire logic channel1_fault_pin_i, // Fault pin level, channel 1
    input wire logic wp_pin_i,           // Write-protect pin level
    input wire logic busy_i,             // Controller busy
    input wire logic calc_pending_i,     // Calculations pending
    input wire logic out_transition_i,   // Outputs in transition
    input wire logic nvm_init_i,         // Nonvolatile memory ready
    input wire logic share_tmo_i,        // Shared timebase clock timeout
    input wire logic ecc_corr_i,         // Memory reports corrections made
    input wire logic restore_all_i,      // Restore-all-user pulse
    input wire logic reset_cmd_i,        // Reset command pulse
    input wire logic bulk_read_i,        // Memory bulk read done pulse
    output logic alert_o,                // Alert request, active high
    output logic vendor_summary_flag_o,  // Status word bit 12 source
    output logic [15:0] status_word_hi_o // Status word bits this bank owns
);
    // ----------------------------------------------------------------
    // Sticky fault bytes
    // ----------------------------------------------------------------
    pmfsb_flag_if cml_if ();  // Comm/logic byte carrier
    pmfsb_flag_if vnd_if ();  // Vendor byte carrier

    // Access decode
    wire logic sel_cml;   // Comm/logic byte selected
    wire logic sel_vnd;   // Vendor byte selected
    wire logic sel_pin;   // Pin word selected
    wire logic sel_hlth;  // Health byte selected
    wire logic sel_ecc;   // ECC word selected
    wire logic sel_mcml;  // Comm/logic mask selected
    wire logic sel_mvnd;  // Vendor mask selected
    wire logic sel_any;   // Any known code
    wire logic sel_ro;    // Read-only register selected

    assign sel_cml = (cmd_code_i == `PMFSB_CMD_COMM_LOGIC);
    assign sel_vnd = (cmd_code_i == `PMFSB_CMD_VENDOR);
    assign sel_pin = (cmd_code_i == `PMFSB_CMD_PIN_STATE);
    assign sel_hlth = (cmd_code_i == `PMFSB_CMD_HEALTH);
    assign sel_ecc = (cmd_code_i == `PMFSB_CMD_ECC_INFO);
    assign sel_mcml = (cmd_code_i == `PMFSB_CMD_MASK_CML);
    assign sel_mvnd = (cmd_code_i == `PMFSB_CMD_MASK_VND);
    assign sel_ro = sel_pin | sel_hlth | sel_ecc;
    assign sel_any = sel_cml | sel_vnd | sel_ro | sel_mcml | sel_mvnd;

    // Drive fault byte carriers
    assign cml_if.set = cml_evt_i;
    assign cml_if.clr_w1c = (cmd_wr_i && sel_cml) ? cmd_wdata_i[7:0] : 8'h00;
    assign cml_if.clr_all = clear_faults_i;
    assign cml_if.clr_log = 1'b0;
    assign vnd_if.set = vnd_evt_i;
    assign vnd_if.clr_w1c = (cmd_wr_i && sel_vnd) ? cmd_wdata_i[7:0] : 8'h00;
    assign vnd_if.clr_all = clear_faults_i;
    assign vnd_if.clr_log = fault_log_clear_i;

    // Comm/logic byte, bit 2 absent
    pmfsb_sticky_byte #(
        .IMPL(`PMFSB_CML_IMPL),
        .W1C(`PMFSB_CML_IMPL),
        .ALLCLR(`PMFSB_CML_IMPL),
        .LOGCLR(8'h00)
    ) u_cml (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .fl(cml_if)
    );

    // Vendor byte, bit 1 absent, bit 3 log-clear only
    pmfsb_sticky_byte #(
        .IMPL(`PMFSB_VND_IMPL),
        .W1C(`PMFSB_VND_W1C),
        .ALLCLR(`PMFSB_VND_W1C),
        .LOGCLR(8'h01 << `PMFSB_VND_LOG_BIT)
    ) u_vnd (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .fl(vnd_if)
    );

    // ----------------------------------------------------------------
    // Alert masks
    // ----------------------------------------------------------------
    logic [7:0] mask_cml_q;  // Comm/logic alert mask
    logic [7:0] mask_vnd_q;  // Vendor alert mask

    // Mask registers, written by command
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mask_cml_q <= `PMFSB_CML_MASK_RST;
            mask_vnd_q <= `PMFSB_VND_MASK_RST;
        end else begin
            if (cmd_wr_i && sel_mcml) begin
                mask_cml_q <= cmd_wdata_i[7:0];
            end
            if (cmd_wr_i && sel_mvnd) begin
                mask_vnd_q <= cmd_wdata_i[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Alert and summary
    // ----------------------------------------------------------------
    wire logic alert_d;    // Any unmasked fault held
    wire logic summary_d;  // Any vendor bit held
    logic alert_q;         // Registered alert
    logic summary_q;       // Registered summary

    assign alert_d = |(cml_if.q & ~mask_cml_q) | |(vnd_if.q & ~mask_vnd_q);
    assign summary_d = |vnd_if.q;

    // Alert and summary registers
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alert_q <= 1'b0;
            summary_q <= 1'b0;
        end else begin
            alert_q <= alert_d;
            summary_q <= summary_d;
        end
    end

    assign alert_o = alert_q;
    assign vendor_summary_flag_o = summary_q;
    assign status_word_hi_o = {3'b000, summary_q, 12'h000};

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire logic [4:0] pin_raw;  // Raw pin levels
    logic [4:0] pin_s1_q;      // First stage
    logic [4:0] pin_s2_q;      // Second stage
    logic [4:0] pin_s3_q;      // Third stage
    logic [4:0] pin_q;         // Accepted levels
    wire logic [4:0] pin_agree; // Stages two and three agree
    wire logic [4:0] pin_d;    // Next accepted levels

    assign pin_raw = {wp_pin_i, channel1_run_pin_i, channel0_run_pin_i, channel1_fault_pin_i, channel0_fault_pin_i};
    assign pin_agree = ~(pin_s2_q ^ pin_s3_q);
    assign pin_d = (pin_agree & pin_s3_q) | (~pin_agree & pin_q);

    // Three-stage sampling, accept on agreement
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            pin_s3_q <= 5'h00;
            pin_q <= 5'h00;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q <= pin_d;
        end
    end

    // ----------------------------------------------------------------
    // ECC status
    // ----------------------------------------------------------------
    logic por_pend_q;   // Refresh owed after power-on reset
    logic ecc_ok_q;     // One when no corrections made
    wire logic ecc_refresh; // Any refresh cause

    assign ecc_refresh = por_pend_q | restore_all_i | reset_cmd_i | bulk_read_i;

    // Capture ECC result on each refresh cause
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            por_pend_q <= 1'b1;
            ecc_ok_q <= `PMFSB_ECC_RST;
        end else begin
            por_pend_q <= 1'b0;
            if (ecc_refresh) begin
                ecc_ok_q <= ~ecc_corr_i;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read assembly
    // ----------------------------------------------------------------
    wire logic [15:0] pin_word;   // Pin-state snapshot
    wire logic [7:0] hlth_byte;   // Common health byte
    wire logic [15:0] ecc_word;   // ECC info word
    wire logic [15:0] rd_mux;     // Selected read value

    assign pin_word = {core_ov_i, core_uv_i, 2'b00, adc_invalid_i, sync_ext_i,
                       pgood_i, run_drv_low_i, pin_q[3:2],
                       fault_drv_low_i, pin_q[1:0]};
    assign hlth_byte = {~alert_q, ~busy_i, ~calc_pending_i, ~out_transition_i,
                        nvm_init_i, 1'b0, share_tmo_i, pin_q[4]};
    assign ecc_word = {10'h000, ecc_ok_q, 5'h00};
    assign rd_mux = sel_cml ? {8'h00, cml_if.q} :
                    sel_vnd ? {8'h00, vnd_if.q} :
                    sel_pin ? pin_word :
                    sel_hlth ? {8'h00, hlth_byte} :
                    sel_ecc ? ecc_word :
                    sel_mcml ? {8'h00, mask_cml_q} :
                    sel_mvnd ? {8'h00, mask_vnd_q} : 16'h0000;

    // Registered read data and error pulse
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_rdata_o <= 16'h0000;
            cmd_err_o <= 1'b0;
        end else begin
            if (cmd_rd_i) begin
                cmd_rdata_o <= rd_mux;
            end
            cmd_err_o <= ((cmd_rd_i || cmd_wr_i) && !sel_any) || (cmd_wr_i && sel_ro);
        end
    end
endmodule : pmfsb_fault_status_bank

//--- rtl/pmfsb_consts.svh
/*
 * Command codes, bit positions, reset values and masks of the fault status bank.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef PMFSB_CONSTS_SVH
`define PMFSB_CONSTS_SVH

// ----------------------------------------------------------------
// Command codes seen by the bank
// ----------------------------------------------------------------
`define PMFSB_CMD_COMM_LOGIC 8'h7E
`define PMFSB_CMD_VENDOR 8'h80
`define PMFSB_CMD_PIN_STATE 8'hE5
`define PMFSB_CMD_HEALTH 8'hEF
`define PMFSB_CMD_ECC_INFO 8'hB6
`define PMFSB_CMD_MASK_CML 8'hF0
`define PMFSB_CMD_MASK_VND 8'hF1

// ----------------------------------------------------------------
// Fault byte layouts
// ----------------------------------------------------------------
`define PMFSB_CML_IMPL 8'hFB
`define PMFSB_VND_IMPL 8'hFD
`define PMFSB_VND_W1C 8'hF5
`define PMFSB_VND_LOG_BIT 3
`define PMFSB_CML_MASK_RST 8'h00
`define PMFSB_VND_MASK_RST 8'h11

// ----------------------------------------------------------------
// Status word and ECC word layouts
// ----------------------------------------------------------------
`define PMFSB_SUMMARY_BIT 12
`define PMFSB_ECC_BIT 5
`define PMFSB_ECC_RST 1'b1

`endif

//--- rtl/pmfsb_pkg.sv
/*
 * Types shared by the fault status bank modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pmfsb_pkg;
    // ----------------------------------------------------------------
    // Data widths
    // ----------------------------------------------------------------
    typedef logic [7:0] pmfsb_byte_t;  // One status byte
    typedef logic [15:0] pmfsb_word_t; // One two-byte value
endpackage : pmfsb_pkg

//--- rtl/pmfsb_flag_if.sv
/*
 * Carrier between the bank top and one sticky fault byte.
 * Assumes the top drives set and clear terms on the same clock as the byte.
 */
`timescale 1ns/1ns
interface pmfsb_flag_if;
    pmfsb_pkg::pmfsb_byte_t set;     // Fault events, one-cycle pulses
    pmfsb_pkg::pmfsb_byte_t clr_w1c; // Write-one clear pattern
    logic clr_all;                   // Clear-all pulse
    logic clr_log;                   // Log-clear pulse
    pmfsb_pkg::pmfsb_byte_t q;       // Latched fault byte

    // ----------------------------------------------------------------
    // Views
    // ----------------------------------------------------------------
    modport owner (output set, output clr_w1c, output clr_all, output clr_log, input q);
    modport flags (input set, input clr_w1c, input clr_all, input clr_log, output q);
endinterface : pmfsb_flag_if

//--- rtl/pmfsb_sticky_byte.sv
/*
 * One sticky fault byte: events latch, write-one and clear-all release.
 * Assumes events are synchronous to ref_clk_i.
 */
`timescale 1ns/1ns
`include "pmfsb_consts.svh"
module pmfsb_sticky_byte #(
    parameter logic [7:0] IMPL = 8'hFF,    // Bits that exist
    parameter logic [7:0] W1C = 8'hFF,     // Bits that writing one clears
    parameter logic [7:0] ALLCLR = 8'hFF,  // Bits that clear-all releases
    parameter logic [7:0] LOGCLR = 8'h00   // Bits that log-clear releases
) (
    input wire logic ref_clk_i,   // Core clock
    input wire logic nrst_i,      // Async reset, active low
    pmfsb_flag_if.flags fl        // Set, clear and value
);
    // ----------------------------------------------------------------
    // Clear and next-value terms
    // ----------------------------------------------------------------
    wire logic [7:0] clr_pat;     // Combined release pattern
    wire logic [7:0] q_d;         // Next byte value
    logic [7:0] q_q;              // Latched byte

    assign clr_pat = (fl.clr_w1c & W1C) | ({8{fl.clr_all}} & ALLCLR) | ({8{fl.clr_log}} & LOGCLR);
    // Set wins over a clear in the same cycle
    assign q_d = ((q_q & ~clr_pat) | fl.set) & IMPL;
    assign fl.q = q_q;

    // Byte storage
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_q <= 8'h00;
        end else begin
            q_q <= q_d;
        end
    end
endmodule : pmfsb_sticky_byte

//--- test/pmfsb_checker.sv
/*
 * Port checker of the fault status bank, bound to its top module.
 * Assumes the command codes of the consts header and one clock domain.
 */
`timescale 1ns/1ns
`include "pmfsb_consts.svh"
module pmfsb_checker (
    input wire logic ref_clk_i,             // Core clock
    input wire logic nrst_i,                // Reset, active low
    input wire logic [7:0] cmd_code_i,      // Command code
    input wire logic cmd_rd_i,              // Read strobe
    input wire logic cmd_wr_i,              // Write strobe
    input wire logic [15:0] cmd_rdata_o,    // Read data
    input wire logic cmd_err_o,             // Refusal pulse
    input wire logic [7:0] cml_evt_i,       // Comm/logic events
    input wire logic [7:0] vnd_evt_i,       // Vendor events
    input wire logic ecc_corr_i,            // Corrections made
    input wire logic restore_all_i,         // Refresh source
    input wire logic reset_cmd_i,           // Refresh source
    input wire logic bulk_read_i,           // Refresh source
    input wire logic alert_o,               // Alert level
    input wire logic vendor_summary_flag_o, // Summary flag
    input wire logic [15:0] status_word_hi_o // Status word bits
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // ----------------------------------------------------------------
    // Named steps
    // ----------------------------------------------------------------
    sequence s_refresh;
        restore_all_i || reset_cmd_i || bulk_read_i;
    endsequence
    sequence s_rd(c);
        cmd_rd_i && cmd_code_i == c;
    endsequence

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_cml_raises_alert: assert property (cml_evt_i[7] |-> ##2 alert_o)
        else $error("alert missing after comm event");
    a_vnd_sets_summary: assert property (vnd_evt_i[7] |-> ##2 vendor_summary_flag_o)
        else $error("summary missing after vendor event");
    a_summary_bit_place: assert property (status_word_hi_o == {3'h0, vendor_summary_flag_o, 12'h000})
        else $error("status word bits misplaced");
    a_ro_write_refused: assert property (cmd_wr_i && (cmd_code_i == `PMFSB_CMD_PIN_STATE
        || cmd_code_i == `PMFSB_CMD_HEALTH || cmd_code_i == `PMFSB_CMD_ECC_INFO) |=> cmd_err_o)
        else $error("read-only write not refused");
    a_ecc_refresh_value: assert property (s_refresh ##1 s_rd(`PMFSB_CMD_ECC_INFO)
        |=> cmd_rdata_o[5] == !$past(ecc_corr_i, 2))
        else $error("ecc bit not refreshed");
    a_ecc_reserved_zero: assert property (s_rd(`PMFSB_CMD_ECC_INFO)
        |=> cmd_rdata_o[15:6] == 10'h000 && cmd_rdata_o[4:0] == 5'h00)
        else $error("ecc word reserved bits set");
    a_health_alert_bit: assert property (s_rd(`PMFSB_CMD_HEALTH)
        |=> cmd_rdata_o[7] == !$past(alert_o) && cmd_rdata_o[2] == 1'b0)
        else $error("health byte alert bit wrong");
    a_cml_bit2_zero: assert property (s_rd(`PMFSB_CMD_COMM_LOGIC)
        |=> cmd_rdata_o[2] == 1'b0 && cmd_rdata_o[15:8] == 8'h00)
        else $error("comm byte reserved bit set");
    a_vnd_bit1_zero: assert property (s_rd(`PMFSB_CMD_VENDOR)
        |=> cmd_rdata_o[1] == 1'b0 && cmd_rdata_o[15:8] == 8'h00)
        else $error("vendor byte bit 1 set");
endmodule : pmfsb_checker

bind pmfsb_fault_status_bank pmfsb_checker pmfsb_checker_i (.ref_clk_i, .nrst_i, .cmd_code_i,
    .cmd_rd_i, .cmd_wr_i, .cmd_rdata_o, .cmd_err_o, .cml_evt_i, .vnd_evt_i, .ecc_corr_i,
    .restore_all_i, .reset_cmd_i, .bulk_read_i, .alert_o, .vendor_summary_flag_o, .status_word_hi_o);

//--- test/pmfsb_host_model.sv
/*
 * Host model: issues command reads and writes to the bank.
 * Assumes access is called right after a rising edge of ref_clk_i.
 */
`timescale 1ns/1ns
`include "pmfsb_consts.svh"
module pmfsb_host_model (
    input wire logic ref_clk_i,          // Core clock
    input wire logic [15:0] cmd_rdata_i, // Read data from bank
    input wire logic cmd_err_i,          // Refusal pulse from bank
    output logic [7:0] cmd_code_o,       // Command code
    output logic cmd_rd_o,               // Read strobe
    output logic cmd_wr_o,               // Write strobe
    output logic [15:0] cmd_wdata_o      // Write data
);
    logic serious = 1'b0; // Internal error seen in comm byte

    initial begin
        cmd_code_o = 8'h00;
        cmd_rd_o = 1'b0;
        cmd_wr_o = 1'b0;
        cmd_wdata_o = 16'h0000;
    end

    // ----------------------------------------------------------------
    // One access: strobe for one edge, answer one cycle later
    // ----------------------------------------------------------------
    task automatic access(input logic r, input logic w, input logic [7:0] c, input logic [15:0] d,
                          output logic [15:0] q, output logic e);
        cmd_code_o <= c;
        cmd_rd_o <= r;
        cmd_wr_o <= w;
        cmd_wdata_o <= d;
        @(posedge ref_clk_i);
        cmd_rd_o <= 1'b0;
        cmd_wr_o <= 1'b0;
        #1;
        q = cmd_rdata_i;
        e = cmd_err_i;
        if (r && c == `PMFSB_CMD_COMM_LOGIC) begin
            serious = q[4] | q[3];
        end
    endtask : access
endmodule : pmfsb_host_model

//--- test/pmfsb_fault_status_bank_test.sv
/*
 * Self-checking bench of the fault status bank with a host model.
 * Assumes the consts header on the include path.
 */
`timescale 1ns/1ns
`include "pmfsb_consts.svh"
module pmfsb_fault_status_bank_test;
    typedef struct packed {
        logic [7:0] code, evt, clr, set_exp, clr_exp;
        logic alert, summ;
    } pmfsb_row_t; // Event, clear pattern, expected bytes and flags
    localparam logic [7:0] cml_c = `PMFSB_CMD_COMM_LOGIC;
    localparam logic [7:0] vnd_c = `PMFSB_CMD_VENDOR;
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, clear_faults_i = 1'b0, fault_log_clear_i = 1'b0;
    logic [7:0] cml_evt_i = 8'h00, vnd_evt_i = 8'h00, cmd_code_i;
    logic core_ov_i = 1'b0, core_uv_i = 1'b0, adc_invalid_i = 1'b0, sync_ext_i = 1'b0;
    logic [1:0] pgood_i = 2'h0, run_drv_low_i = 2'h0, fault_drv_low_i = 2'h0;
    logic channel0_run_pin_i = 1'b0, channel1_run_pin_i = 1'b0, channel0_fault_pin_i = 1'b0;
    logic channel1_fault_pin_i = 1'b0, wp_pin_i = 1'b0, busy_i = 1'b0, calc_pending_i = 1'b0;
    logic out_transition_i = 1'b0, nvm_init_i = 1'b0, share_tmo_i = 1'b0, ecc_corr_i = 1'b0;
    logic restore_all_i = 1'b0, reset_cmd_i = 1'b0, bulk_read_i = 1'b0, cmd_rd_i, cmd_wr_i, cmd_err_o;
    logic alert_o, vendor_summary_flag_o, er;
    logic [15:0] cmd_wdata_i, cmd_rdata_o, status_word_hi_o, rd;
    int err_count = 0, n_compared = 0, cycles = 0;
    pmfsb_row_t rows [5] = '{'{cml_c, 8'hFF, 8'h80, 8'hFB, 8'h7B, 1'b1, 1'b0},
        '{cml_c, 8'h00, 8'h08, 8'h7B, 8'h73, 1'b1, 1'b0}, '{cml_c, 8'h00, 8'h73, 8'h73, 8'h00, 1'b0, 1'b0},
        '{vnd_c, 8'hF7, 8'h10, 8'hF5, 8'hE5, 1'b1, 1'b1}, '{vnd_c, 8'h00, 8'hE5, 8'hE5, 8'h00, 1'b0, 1'b0}};
    logic [15:0] pins [2] = '{16'h89A5, 16'h465A}; // Pin word vectors
    logic [5:0] hlv [2] = '{6'h2F, 6'h10};          // Busy, calc, transit, nvm, timeout, wp
    logic [7:0] hexp [2] = '{8'hAB, 8'hD0};         // Health bytes expected

    pmfsb_fault_status_bank pmfsb_fault_status_bank_i (.ref_clk_i, .nrst_i, .cmd_code_i, .cmd_rd_i,
        .cmd_wr_i, .cmd_wdata_i, .cmd_rdata_o, .cmd_err_o, .clear_faults_i, .fault_log_clear_i,
        .cml_evt_i, .vnd_evt_i, .core_ov_i, .core_uv_i, .adc_invalid_i, .sync_ext_i, .pgood_i,
        .run_drv_low_i, .fault_drv_low_i, .channel0_run_pin_i, .channel1_run_pin_i,
        .channel0_fault_pin_i, .channel1_fault_pin_i, .wp_pin_i, .busy_i, .calc_pending_i,
        .out_transition_i, .nvm_init_i, .share_tmo_i, .ecc_corr_i, .restore_all_i, .reset_cmd_i,
        .bulk_read_i, .alert_o, .vendor_summary_flag_o, .status_word_hi_o);
    pmfsb_host_model pmfsb_host_model_i (.ref_clk_i, .cmd_rdata_i(cmd_rdata_o), .cmd_err_i(cmd_err_o),
        .cmd_code_o(cmd_code_i), .cmd_rd_o(cmd_rd_i), .cmd_wr_o(cmd_wr_i), .cmd_wdata_o(cmd_wdata_i));

    // ----------------------------------------------------------------
    // Clock and hang guard
    // ----------------------------------------------------------------
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic evt(input logic [7:0] c, input logic [7:0] v, input logic [4:0] p);
        @(posedge ref_clk_i);
        cml_evt_i <= c;
        vnd_evt_i <= v;
        {clear_faults_i, fault_log_clear_i, restore_all_i, reset_cmd_i, bulk_read_i} <= p;
    endtask : evt
    task automatic rw(input logic r, input logic w, input logic [7:0] c, input logic [15:0] d);
        @(posedge ref_clk_i);
        {cml_evt_i, vnd_evt_i, clear_faults_i, fault_log_clear_i, restore_all_i, reset_cmd_i,
            bulk_read_i} <= '0; // Pulses last one cycle
        pmfsb_host_model_i.access(r, w, c, d, rd, er);
    endtask : rw
    task automatic tally_and_finish();
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk_i);
        chk("alert in reset", alert_o, 16'h0000);
        nrst_i <= 1'b1;
        foreach (rows[i]) begin
            evt(rows[i].code == cml_c ? rows[i].evt : 8'h00, rows[i].code == vnd_c ? rows[i].evt : 8'h00, 5'h00);
            rw(1'b1, 1'b0, rows[i].code, 16'h0000);
            chk("set byte", rd, {8'h00, rows[i].set_exp});
            if (rows[i].code == cml_c) chk("serious", pmfsb_host_model_i.serious, |rows[i].set_exp[4:3]);
            rw(1'b0, 1'b1, rows[i].code, {8'h00, rows[i].clr});
            rw(1'b1, 1'b0, rows[i].code, 16'h0000);
            chk("cleared byte", rd, {8'h00, rows[i].clr_exp});
            chk("alert", alert_o, rows[i].alert);
            chk("summary", vendor_summary_flag_o, rows[i].summ);
            chk("status word", status_word_hi_o, {3'h0, rows[i].summ, 12'h000});
        end
        rw(1'b1, 1'b0, `PMFSB_CMD_MASK_VND, 16'h0000);
        chk("vendor mask", rd, 16'h0011);
        rw(1'b1, 1'b0, 8'h00, 16'h0000);
        chk("unknown read err", er, 16'h0001);
        rw(1'b0, 1'b1, `PMFSB_CMD_PIN_STATE, 16'hFFFF);
        chk("ro write err", er, 16'h0001);
        evt(8'h00, 8'h08, 5'h00);
        rw(1'b0, 1'b1, vnd_c, 16'h00FF);
        evt(8'h00, 8'h00, 5'h10);
        rw(1'b1, 1'b0, vnd_c, 16'h0000);
        chk("log bit kept", rd, 16'h0008);
        evt(8'h00, 8'h00, 5'h08);
        rw(1'b1, 1'b0, vnd_c, 16'h0000);
        chk("log bit cleared", rd, 16'h0000);
        evt(8'h00, 8'h01, 5'h10);
        rw(1'b1, 1'b0, vnd_c, 16'h0000);
        chk("set over clear", rd, 16'h0001);
        chk("masked alert", alert_o, 16'h0000);
        chk("summary", vendor_summary_flag_o, 16'h0001);
        rw(1'b0, 1'b1, `PMFSB_CMD_MASK_VND, 16'h0000);
        rw(1'b1, 1'b0, vnd_c, 16'h0000);
        chk("unmasked alert", alert_o, 16'h0001);
        rw(1'b0, 1'b1, `PMFSB_CMD_MASK_VND, 16'h0011);
        evt(8'h00, 8'h00, 5'h10);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk_i);
            ecc_corr_i <= !i[0];
            evt(8'h00, 8'h00, 5'h04 >> i);
            rw(1'b1, 1'b0, `PMFSB_CMD_ECC_INFO, 16'h0000);
            chk("ecc word", rd, {10'h000, i[0], 5'h00});
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk_i);
            {core_ov_i, core_uv_i, adc_invalid_i, sync_ext_i} <= {pins[i][15:14], pins[i][11:10]};
            {pgood_i, run_drv_low_i, channel1_run_pin_i, channel0_run_pin_i} <= pins[i][9:4];
            {fault_drv_low_i, channel1_fault_pin_i, channel0_fault_pin_i} <= pins[i][3:0];
            {busy_i, calc_pending_i, out_transition_i, nvm_init_i, share_tmo_i, wp_pin_i} <= hlv[i];
            repeat (6) @(posedge ref_clk_i);
            rw(1'b1, 1'b0, `PMFSB_CMD_PIN_STATE, 16'h0000);
            chk("pin word", rd, pins[i]);
            rw(1'b1, 1'b0, `PMFSB_CMD_HEALTH, 16'h0000);
            chk("health byte", rd, {8'h00, hexp[i]});
        end
        evt(8'h00, 8'h80, 5'h00);
        rw(1'b1, 1'b0, vnd_c, 16'h0000);
        chk("alert before reset", alert_o, 16'h0001);
        @(posedge ref_clk_i);
        {ecc_corr_i, nrst_i} <= 2'b10;
        repeat (2) @(posedge ref_clk_i);
        chk("alert in reset", alert_o, 16'h0000);
        nrst_i <= 1'b1;
        rw(1'b1, 1'b0, vnd_c, 16'h0000);
        chk("vendor after reset", rd, 16'h0000);
        rw(1'b1, 1'b0, `PMFSB_CMD_ECC_INFO, 16'h0000);
        chk("ecc after reset", rd, 16'h0000);
        tally_and_finish();
    end
endmodule : pmfsb_fault_status_bank_test
